// ### src/irq_line_defines.svh
// Constants for the remote interrupt routing and dual image width registers
// Contract
// - Four-bit read/write remote interrupt pin selector
// - Selector zero disables remote interrupt routing
// - Code one: port0 remote, port1 main
// - Codes 1000-1111: remote interrupt combines both ports (port0 only in dual-link mode); codes 0010-0111 route nothing
// - Codes 1000-1011 route to local pins
// - Codes 1100-1111 route to alternate pins
// - Thirteen-bit width split over two registers
// - Width resets to 1280 pixels
// - Splitter line is twice the width
// - Dual-DSI mode uses same width
`ifndef IRQ_LINE_DEFINES_SVH
`define IRQ_LINE_DEFINES_SVH
`define ADDR_WIDTH_LOW    8'h32
`define ADDR_WIDTH_HIGH   8'h33
`define ADDR_IRQ_ROUTING  8'h30
`define ADDR_EVT_STATUS   8'h40
`define ADDR_EVT_MASK     8'h41
`define RST_WIDTH_LOW     8'h00
`define RST_WIDTH_HIGH    5'h05
`define RST_ROUTING       4'h0
`define EVT_BITS          2
`define WIDTH_LIMIT       13'h1000
`endif

// ### src/irq_line_pkg.sv
// Types shared by the routing register bank
`default_nettype none
package irq_line_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;
  typedef enum logic [1:0] {
    ROUTE_OFF   = 2'b00,
    ROUTE_SPLIT = 2'b01,
    ROUTE_LOCAL = 2'b10,
    ROUTE_ALT   = 2'b11
  } route_kind_t;
endpackage : irq_line_pkg
`default_nettype wire

// ### src/pin_sync.sv
// Three-flop input synchroniser that reports a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Pin and clean level
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) level <= 1'b0;
    else if (s2 == s3) level <= s3;
  end
endmodule : pin_sync
`default_nettype wire

// ### src/remote_irq_route_line_size_regs.sv
// Remote interrupt routing selector and dual image width register bank
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_line_defines.svh"
module remote_irq_route_line_size_regs (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Register port
  input  wire irq_line_pkg::reg_req_t req,
  output logic [7:0]                  rdata,
  // Remote interrupt sources from the link ports, dual-link mode and the local main interrupt
  input  wire logic                   port0_remote_irq,
  input  wire logic                   port1_remote_irq,
  input  wire logic                   dual_link_mode,
  input  wire logic                   local_main_irq,
  // Interrupt outputs
  output logic                        remote_irq_out,
  output logic                        main_irq_out,
  output logic [3:0]                  gpio_irq_out,
  output logic [3:0]                  alt_gpio_irq_out,
  output logic                        event_irq,
  // Splitter parameters
  output logic [12:0]                 dual_image_width,
  output logic [13:0]                 combined_line_width,
  output logic                        width_over_limit
);
  import irq_line_pkg::*;

  logic [3:0]  remote_irq_pin_select;
  logic [7:0]  dual_image_width_lo;
  logic [4:0]  dual_image_width_hi;
  logic [`EVT_BITS-1:0] evt_status;
  logic [`EVT_BITS-1:0] evt_mask;
  logic [`EVT_BITS-1:0] evt_set;
  logic        p0;
  logic        p1;
  logic        p0_d;
  logic        p1_d;
  logic        remote_any;
  route_kind_t route_kind;
  logic        wr_routing;
  logic        wr_low;
  logic        wr_high;
  logic        wr_status;
  logic        wr_mask;

  // Remote interrupts come from the link receivers on another timing
  pin_sync u_sync0 (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (port0_remote_irq),
    .level (p0)
  );
  pin_sync u_sync1 (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (port1_remote_irq),
    .level (p1)
  );

  assign wr_routing = req.wr && (req.addr == `ADDR_IRQ_ROUTING);
  assign wr_low     = req.wr && (req.addr == `ADDR_WIDTH_LOW);
  assign wr_high    = req.wr && (req.addr == `ADDR_WIDTH_HIGH);
  assign wr_status  = req.wr && (req.addr == `ADDR_EVT_STATUS);
  assign wr_mask    = req.wr && (req.addr == `ADDR_EVT_MASK);

  // Selector register; upper nibble is reserved and dropped on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) remote_irq_pin_select <= `RST_ROUTING;
    else if (wr_routing) remote_irq_pin_select <= req.wdata[3:0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dual_image_width_lo <= `RST_WIDTH_LOW;
    else if (wr_low) dual_image_width_lo <= req.wdata;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) dual_image_width_hi <= `RST_WIDTH_HIGH;
    else if (wr_high) dual_image_width_hi <= req.wdata[4:0];
  end

  // Splitter and dual-DSI both see the same 2D width; combined line is double
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_image_width    <= {`RST_WIDTH_HIGH, `RST_WIDTH_LOW};
      combined_line_width <= {`RST_WIDTH_HIGH, `RST_WIDTH_LOW, 1'b0};
      width_over_limit    <= 1'b0;
    end else begin
      dual_image_width    <= {dual_image_width_hi, dual_image_width_lo};
      combined_line_width <= {dual_image_width_hi, dual_image_width_lo, 1'b0};
      // Hardware does not clamp; the flag only warns software of a bad value
      width_over_limit    <= {dual_image_width_hi, dual_image_width_lo} > `WIDTH_LIMIT;
    end
  end

  always_comb begin
    unique case (remote_irq_pin_select[3:2])
      2'b00:   route_kind = (remote_irq_pin_select[1:0] == 2'b01) ? ROUTE_SPLIT : ROUTE_OFF;
      2'b01:   route_kind = ROUTE_OFF;
      2'b10:   route_kind = ROUTE_LOCAL;
      2'b11:   route_kind = ROUTE_ALT;
    endcase
  end

  // Combined unless dual-link treats both links as one stream
  assign remote_any = dual_link_mode ? p0 : (p0 | p1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remote_irq_out   <= 1'b0;
      main_irq_out     <= 1'b0;
      gpio_irq_out     <= 4'h0;
      alt_gpio_irq_out <= 4'h0;
    end else begin
      remote_irq_out   <= (route_kind == ROUTE_SPLIT) & p0;
      main_irq_out     <= local_main_irq | ((route_kind == ROUTE_SPLIT) & p1);
      gpio_irq_out     <= 4'h0;
      alt_gpio_irq_out <= 4'h0;
      if (route_kind == ROUTE_LOCAL)
        gpio_irq_out[remote_irq_pin_select[1:0]] <= remote_any;
      if (route_kind == ROUTE_ALT)
        alt_gpio_irq_out[remote_irq_pin_select[1:0]] <= remote_any;
    end
  end

  // Events: rising edge of each port's remote interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p0_d <= 1'b0;
      p1_d <= 1'b0;
    end else begin
      p0_d <= p0;
      p1_d <= p1;
    end
  end
  assign evt_set = {p1 & ~p1_d, p0 & ~p0_d};

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) evt_status <= '0;
    else evt_status <= (evt_status & ~(wr_status ? req.wdata[`EVT_BITS-1:0] : '0)) | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) evt_mask <= '0;
    else if (wr_mask) evt_mask <= req.wdata[`EVT_BITS-1:0];
  end

  assign event_irq = |(evt_status & evt_mask);

  // Read data valid the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else if (req.rd) begin
      unique case (req.addr)
        `ADDR_IRQ_ROUTING: rdata <= {4'h0, remote_irq_pin_select};
        `ADDR_WIDTH_LOW:   rdata <= dual_image_width_lo;
        `ADDR_WIDTH_HIGH:  rdata <= {3'h0, dual_image_width_hi};
        `ADDR_EVT_STATUS:  rdata <= {6'h00, evt_status};
        `ADDR_EVT_MASK:    rdata <= {6'h00, evt_mask};
        default:           rdata <= 8'h00;
      endcase
    end else rdata <= 8'h00;
  end
endmodule : remote_irq_route_line_size_regs
`default_nettype wire

// ### bench/irq_route_asserts.sv
// Port-level checks for the routing and width register bank
`timescale 1ns/1ps
`default_nettype none
module irq_route_asserts (
  // Clock, reset and register port
  input wire logic                   clk,
  input wire logic                   rst_n,
  input wire irq_line_pkg::reg_req_t req,
  input wire logic [7:0]             rdata,
  // Interrupt side
  input wire logic                   port0_remote_irq,
  input wire logic                   remote_irq_out,
  input wire logic [3:0]             gpio_irq_out,
  input wire logic [3:0]             alt_gpio_irq_out,
  // Width side
  input wire logic [12:0]            dual_image_width,
  input wire logic [13:0]            combined_line_width
);
  import irq_line_pkg::*;
  logic [3:0] sel;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the selector, since the bank does not expose it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sel <= 4'h0;
    else if (req.wr && req.addr == 8'h30) sel <= req.wdata[3:0];
  end
  width_double_a: assert property (combined_line_width == {dual_image_width, 1'b0})
    else $error("combined width wrong");
  width_low_a: assert property (req.wr && req.addr == 8'h32 |-> ##2 dual_image_width[7:0] == $past(req.wdata, 2))
    else $error("low width byte wrong");
  width_high_a: assert property (req.wr && req.addr == 8'h33 |-> ##2 dual_image_width[12:8] == $past(req.wdata[4:0], 2))
    else $error("high width field wrong");
  high_rsvd_a: assert property (req.rd && req.addr == 8'h33 |=> rdata[7:5] == 3'b000)
    else $error("reserved width bits set");
  route_rsvd_a: assert property (req.rd && req.addr == 8'h30 |=> rdata[7:4] == 4'h0)
    else $error("reserved routing bits set");
  route_off_a: assert property (sel == 4'h0 && $stable(sel) |-> !remote_irq_out && (gpio_irq_out | alt_gpio_irq_out) == 4'h0)
    else $error("routing off but pin active");
  gpio_pick_a: assert property (sel[3:2] == 2'b10 && $stable(sel) |-> (gpio_irq_out & ~(4'h1 << sel[1:0])) == 4'h0 && alt_gpio_irq_out == 4'h0)
    else $error("wrong local pin");
  alt_pick_a: assert property (sel[3:2] == 2'b11 && $stable(sel) |-> (alt_gpio_irq_out & ~(4'h1 << sel[1:0])) == 4'h0 && gpio_irq_out == 4'h0)
    else $error("wrong alternate pin");
  remote_only_a: assert property (sel != 4'h1 && $stable(sel) |-> !remote_irq_out)
    else $error("remote output without split code");
  remote_follow_a: assert property ((sel == 4'h1 && port0_remote_irq)[*8] |-> remote_irq_out)
    else $error("remote output missed port0");
endmodule : irq_route_asserts
`default_nettype wire

// ### bench/remote_irq_route_line_size_regs_tb_top.sv
// Testbench for the routing and width register bank
`timescale 1ns/1ps
`default_nettype none
module remote_irq_route_line_size_regs_tb_top;
  import irq_line_pkg::*;
  logic clk = 0, rst_n = 0, p0 = 0, p1 = 0, dl = 0, lm = 0, ro, mo, ev, ovr;
  reg_req_t req = '0;
  logic [7:0] rdata;
  logic [3:0] g, ag;
  logic [12:0] w;
  logic [13:0] cw;
  int fails = 0, checks_done = 0;
  remote_irq_route_line_size_regs DUT (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .port0_remote_irq(p0), .port1_remote_irq(p1), .dual_link_mode(dl), .local_main_irq(lm),
    .remote_irq_out(ro), .main_irq_out(mo), .gpio_irq_out(g), .alt_gpio_irq_out(ag),
    .event_irq(ev), .dual_image_width(w), .combined_line_width(cw), .width_over_limit(ovr));
  initial forever #20 clk = ~clk;
  task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 cmp({6'h00, rdata}, {6'h00, e});
  endtask : rd
  task automatic t_width();
    rd(8'h32, 8'h00);
    rd(8'h33, 8'h05);
    cmp(cw, 14'h0a00);
    wr(8'h33, 8'hff);
    rd(8'h33, 8'h1f);
    wr(8'h32, 8'h01);
    cmp({ovr, w}, 14'h3f01);
    cmp(cw, 14'h3e02);
    wr(8'h33, 8'h10);
    wr(8'h32, 8'h00);
    cmp({ovr, w}, 14'h1000);
    $display("width test done");
  endtask : t_width
  task automatic t_route();
    @(posedge clk);
    p0 <= 1'b1;
    rd(8'h30, 8'h00);
    wr(8'h30, 8'h02);
    cmp({ro, mo, g, ag}, 14'h000);
    wr(8'h30, 8'hf1);
    rd(8'h30, 8'h01);
    cmp({ro, mo, g, ag}, 14'h200);
    @(posedge clk);
    p0 <= 1'b0;
    p1 <= 1'b1;
    repeat (8) @(posedge clk);
    cmp({ro, mo, g, ag}, 14'h100);
    for (int c = 8; c < 16; c++) begin
      wr(8'h30, 8'(c));
      cmp({ro, mo, g, ag}, 14'(c < 12 ? 8'h10 << c[1:0] : 8'h01 << c[1:0]));
    end
    dl <= 1'b1;
    wr(8'h30, 8'h08);
    cmp({ro, mo, g, ag}, 14'h000);
    // Combined remote is high again here, so a leak through code zero would show
    dl <= 1'b0;
    lm <= 1'b1;
    wr(8'h30, 8'h00);
    cmp({ro, mo, g, ag}, 14'h100);
    lm <= 1'b0;
    repeat (2) @(posedge clk);
    cmp({ro, mo, g, ag}, 14'h000);
    $display("route test done");
  endtask : t_route
  task automatic t_event();
    rd(8'h40, 8'h03);
    cmp({13'h0, ev}, 14'h0);
    wr(8'h41, 8'h02);
    cmp({13'h0, ev}, 14'h1);
    wr(8'h40, 8'h02);
    rd(8'h40, 8'h01);
    cmp({13'h0, ev}, 14'h0);
    rd(8'h7f, 8'h00);
    $display("event test done");
  endtask : t_event
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_width();
    t_route();
    t_event();
    tally_and_finish();
  end
  initial begin
    #200us;
    fails++;
    tally_and_finish();
  end
endmodule : remote_irq_route_line_size_regs_tb_top
bind remote_irq_route_line_size_regs irq_route_asserts u_chk (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
  .port0_remote_irq(port0_remote_irq), .remote_irq_out(remote_irq_out), .gpio_irq_out(gpio_irq_out),
  .alt_gpio_irq_out(alt_gpio_irq_out), .dual_image_width(dual_image_width), .combined_line_width(combined_line_width));
`default_nettype wire
